// [src/imc_pkg.sv]
// constants and types for the mode-control register of sources 56 to 59
// assumes a single AHB-Lite master and one system clock
// Overview of operation
// - bit 7 and bit 3 of every slot always read zero
// - trigger bit clear: source never raises a dma activation request
// - trigger bit in slot 0 makes source 56 a dma request
// - trigger bit in slots 1 and 2 does likewise for sources 57, 58
// - trigger clear: level 000 disables, 001 to 111 give priority 1 to 7
// - trigger set: level field selects a dma channel instead of priority
// - dma codes 000 to 111 route to channels zero to seven
package imc_pkg;
   localparam logic [31:0] IMC_ADDR_MODE = 32'hffffe038;
   localparam logic [31:0] IMC_RESET = 32'h00000000;
   localparam logic [7:0] IMC_SLOT_MASK = 8'h77;
   localparam int IMC_SLOTS = 4;
   localparam int IMC_SLOT_W = 8;
   localparam int IMC_DMA_BIT = 4;
   localparam int IMC_ACT_LO = 5;
   localparam int IMC_ACT_W = 2;
   localparam int IMC_LVL_W = 3;
   localparam logic [1:0] IMC_ACT_FALLING = 2'h2;
   localparam logic [2:0] IMC_LEVEL_OFF = 3'h0;
   localparam logic [1:0] IMC_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] IMC_HTRANS_SEQ = 2'h3;

   // decoded view of one slot
   typedef struct packed {
      logic irq_en;
      logic [2:0] irq_level;
      logic dma_req_en;
      logic [2:0] dma_channel;
   } imc_slot_t;
endpackage : imc_pkg

// [src/imc_slot.sv]
// decodes one byte slot into interrupt and dma routing
// assumes the slot byte comes straight from the register
module imc_slot (
   input wire logic [7:0] slot,
   output imc_pkg::imc_slot_t route
);
   import imc_pkg::*;

   logic dma_sel;
   logic [2:0] lvl;
   assign dma_sel = slot[IMC_DMA_BIT];
   assign lvl = slot[IMC_LVL_W-1:0];

   // dma mode steals the level field as a channel number
   always_comb begin
      route.dma_req_en = dma_sel;
      route.dma_channel = dma_sel ? lvl : IMC_LEVEL_OFF;
      route.irq_level = dma_sel ? IMC_LEVEL_OFF : lvl;
      route.irq_en = !dma_sel && (lvl != IMC_LEVEL_OFF);
   end
endmodule : imc_slot

// [src/imc_mode_ctrl.sv]
// mode-control register for interrupt sources 56 to 59, AHB-Lite slave
// assumes hready is this slave's hreadyout; zero wait states, OKAY always
module imc_mode_ctrl (
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output imc_pkg::imc_slot_t route_src56,
   output imc_pkg::imc_slot_t route_src57,
   output imc_pkg::imc_slot_t route_src58,
   output imc_pkg::imc_slot_t route_src59,
   output logic [3:0] bad_edge_cfg
);
   import imc_pkg::*;

   logic [31:0] mode_reg;
   logic wr_pend;
   logic rd_pend;
   logic addr_hit;
   logic take;
   logic [31:0] wmask;
   imc_slot_t routes [IMC_SLOTS];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign take = hsel && hready && (htrans == IMC_HTRANS_NONSEQ || htrans == IMC_HTRANS_SEQ);
   assign addr_hit = (haddr == IMC_ADDR_MODE);
   assign wmask = {IMC_SLOT_MASK, IMC_SLOT_MASK, IMC_SLOT_MASK, IMC_SLOT_MASK};

   // address phase capture; unmapped addresses read zero, writes dropped
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
      end else if (clk_en) begin
         wr_pend <= take && hwrite && addr_hit;
         rd_pend <= take && !hwrite && addr_hit;
      end
   end

   // register store; reserved bits are masked so they never hold a one
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_reg <= IMC_RESET;
      end else if (clk_en && wr_pend) begin
         mode_reg <= hwdata & wmask;
      end
   end

   // read data registered so it stands for the data phase
   always_ff @(posedge clock) begin
      if (rst) begin
         hrdata <= IMC_RESET;
      end else if (clk_en) begin
         // a write in its data phase lands at this same edge, so a read
         // pipelined behind it must be handed the new word, not the stale one
         if (take && !hwrite && addr_hit && wr_pend) begin
            hrdata <= hwdata & wmask;
         end else if (take && !hwrite && addr_hit) begin
            hrdata <= mode_reg;
         end else begin
            hrdata <= IMC_RESET;
         end
      end
   end

   // per-slot decode and active-state check
   genvar g;
   generate
      for (g = 0; g < IMC_SLOTS; g++) begin : g_slot
         imc_slot u_slot (
            .slot(mode_reg[g*IMC_SLOT_W +: IMC_SLOT_W]),
            .route(routes[g])
         );
         // flags software that broke the falling-edge requirement
         assign bad_edge_cfg[g] =
            mode_reg[g*IMC_SLOT_W+IMC_ACT_LO +: IMC_ACT_W] != IMC_ACT_FALLING;
      end
   endgenerate

   assign route_src56 = routes[0];
   assign route_src57 = routes[1];
   assign route_src58 = routes[2];
   assign route_src59 = routes[3];

   property p_reserved_zero;
      @(posedge clock) disable iff (rst)
         (mode_reg & ~wmask) == 32'h00000000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_no_dma_when_clear;
      @(posedge clock) disable iff (rst)
         !mode_reg[IMC_DMA_BIT] |-> !route_src56.dma_req_en;
   endproperty
   a_no_dma_when_clear: assert property (p_no_dma_when_clear) else $error("dma req leak");

   property p_src56_dma;
      @(posedge clock) disable iff (rst)
         mode_reg[IMC_DMA_BIT] |-> route_src56.dma_req_en && !route_src56.irq_en;
   endproperty
   a_src56_dma: assert property (p_src56_dma) else $error("src56 not dma");

   property p_src57_dma;
      @(posedge clock) disable iff (rst)
         mode_reg[IMC_SLOT_W+IMC_DMA_BIT] == route_src57.dma_req_en;
   endproperty
   a_src57_dma: assert property (p_src57_dma) else $error("src57 dma mismatch");

   property p_level;
      @(posedge clock) disable iff (rst)
         !mode_reg[IMC_DMA_BIT] |-> route_src56.irq_level == mode_reg[IMC_LVL_W-1:0]
            && route_src56.irq_en == (mode_reg[IMC_LVL_W-1:0] != IMC_LEVEL_OFF);
   endproperty
   a_level: assert property (p_level) else $error("priority wrong");

   property p_channel;
      @(posedge clock) disable iff (rst)
         mode_reg[IMC_DMA_BIT] |-> route_src56.dma_channel == mode_reg[IMC_LVL_W-1:0];
   endproperty
   a_channel: assert property (p_channel) else $error("channel wrong");

   sequence s_write_taken;
      take && hwrite && addr_hit && clk_en;
   endsequence
   property p_write_lands;
      @(posedge clock) disable iff (rst)
         s_write_taken ##1 clk_en |=> mode_reg == ($past(hwdata) & wmask);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write lost");

   property p_reset_zero;
      @(posedge clock) rst |=> mode_reg == 32'h00000000 && hrdata == 32'h00000000;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

   // after reset every source is off on both sides and every slot flags its edge
   property p_reset_routes;
      @(posedge clock) rst |=> bad_edge_cfg == 4'hf
         && {route_src59, route_src58, route_src57, route_src56} == 32'h00000000;
   endproperty
   a_reset_routes: assert property (p_reset_routes) else $error("reset routes");

   property p_src58_dma;
      @(posedge clock) disable iff (rst)
         mode_reg[2*IMC_SLOT_W+IMC_DMA_BIT] == route_src58.dma_req_en;
   endproperty
   a_src58_dma: assert property (p_src58_dma) else $error("src58 dma mismatch");

   // read path: the captured word stands one data phase, then the bus idles at zero
   sequence s_read_taken;
      take && !hwrite && addr_hit && clk_en;
   endsequence
   property p_read_data;
      @(posedge clock) disable iff (rst)
         s_read_taken |=> hrdata ==
            ($past(wr_pend) ? ($past(hwdata) & wmask) : $past(mode_reg));
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data wrong");

   property p_read_idle;
      @(posedge clock) disable iff (rst)
         !rd_pend |-> hrdata == IMC_RESET;
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("stale read");

   property p_read_reserved;
      @(posedge clock) disable iff (rst)
         (hrdata & ~wmask) == IMC_RESET;
   endproperty
   a_read_reserved: assert property (p_read_reserved) else $error("reserved read");

   // an address that misses the register reads back zero
   property p_unmapped_read;
      @(posedge clock) disable iff (rst)
         take && !hwrite && !addr_hit && clk_en |=> hrdata == IMC_RESET;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("miss not zero");

   // nothing but a pending bus write may move the register
   property p_no_stray_write;
      @(posedge clock) disable iff (rst)
         clk_en && !wr_pend |=> $stable(mode_reg);
   endproperty
   a_no_stray_write: assert property (p_no_stray_write) else $error("stray write");

   // a low clock enable holds every flop, the bus side included; the bus is
   // not stalled meanwhile, so a transfer made while frozen is simply lost
   property p_freeze;
      @(posedge clock) disable iff (rst)
         !clk_en |=> $stable(mode_reg) && $stable(hrdata) && $stable(wr_pend)
            && $stable(rd_pend);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   // the slave never stalls and never errors
   property p_okay;
      @(posedge clock) disable iff (rst)
         hreadyout && !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");

   // every slot keeps the two sides apart: a source is never both a dma request
   // and an interrupt, and its level field shows up on exactly one of them
   generate
      for (g = 0; g < IMC_SLOTS; g++) begin : g_chk
         property p_slot_route;
            @(posedge clock) disable iff (rst)
               routes[g].dma_req_en == mode_reg[g*IMC_SLOT_W+IMC_DMA_BIT]
                  && (routes[g].dma_req_en ? !routes[g].irq_en
                     : routes[g].dma_channel == IMC_LEVEL_OFF);
         endproperty
         a_slot_route: assert property (p_slot_route) else $error("slot mixed");

         property p_slot_field;
            @(posedge clock) disable iff (rst)
               (routes[g].dma_req_en ? routes[g].dma_channel : routes[g].irq_level)
                  == mode_reg[g*IMC_SLOT_W +: IMC_LVL_W];
         endproperty
         a_slot_field: assert property (p_slot_field) else $error("slot field");
      end
   endgenerate
endmodule : imc_mode_ctrl

// [test/imc_mode_ctrl_tb_top.sv]
// bench for the mode-control register of sources 56 to 59
// assumes the slave is alone on the bus, so its hreadyout is hready
module imc_mode_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import imc_pkg::*;
   logic clock = 1'b0, rst = 1'b1, hwrite = 1'b0, hreadyout, hresp;
   logic clk_en = 1'b1, hsel = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [3:0] bad_edge_cfg;
   imc_slot_t route_src56, route_src57, route_src58, route_src59;
   int error_cnt = 0, n_compared = 0;
   // written word beside its expected readback
   logic [31:0] rows [8][2] = '{'{32'hffffffff, 32'h77777777},
      '{32'h50545c44, 32'h50545444}, '{32'h4746c140, 32'h47464140},
      '{32'h53525150, 32'h53525150}, '{32'h5f5e5d5c, 32'h57565554},
      '{32'h43424140, 32'h43424140}, '{32'h47464544, 32'h47464544},
      '{32'h00000000, 32'h00000000}};

   imc_mode_ctrl i_dut (.clock(clock), .rst(rst), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .route_src56(route_src56), .route_src57(route_src57),
      .route_src58(route_src58), .route_src59(route_src59),
      .bad_edge_cfg(bad_edge_cfg));

   initial forever #10 clock = ~clock;

   // expected decode of one slot, worked out from the field meanings
   function automatic imc_slot_t er(input logic [7:0] b);
      er = b[4] ? {4'h0, 1'b1, b[2:0]} : {b[2:0] != 3'h0, b[2:0], 4'h0};
   endfunction : er

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one single transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= IMC_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   // read back and compare register, routes and edge status
   task automatic chk_all(input logic [31:0] x);
      bus(1'b0, IMC_ADDR_MODE, 32'h0);
      chk(rd, x);
      @(negedge clock);
      chk({route_src59, route_src58, route_src57, route_src56},
         {er(x[31:24]), er(x[23:16]), er(x[15:8]), er(x[7:0])});
      for (int g = 0; g < 4; g++)
         chk({31'h0, bad_edge_cfg[g]}, {31'h0, x[8*g+5 +: 2] != IMC_ACT_FALLING});
      chk({31'h0, hresp}, 32'h0);
      chk({31'h0, hreadyout}, 32'h1);
      @(posedge clock);
   endtask : chk_all

   task automatic print_verdict;
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   // a hang would stall the bus tasks forever
   initial begin
      #50000;
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk_all(IMC_RESET);
      foreach (rows[i]) begin
         bus(1'b1, IMC_ADDR_MODE, rows[i][0]);
         chk_all(rows[i][1]);
      end
      // unmapped neighbour: write ignored, read zero
      bus(1'b1, 32'hffffe03c, 32'h44444444);
      bus(1'b0, 32'hffffe03c, 32'h0);
      chk(rd, 32'h0);
      chk_all(32'h0);
      // frozen clock enable, then a deselected slave: both writes are dropped
      clk_en <= 1'b0;
      bus(1'b1, IMC_ADDR_MODE, 32'h51515151);
      clk_en <= 1'b1;
      hsel <= 1'b0;
      bus(1'b1, IMC_ADDR_MODE, 32'h52525252);
      hsel <= 1'b1;
      chk_all(32'h0);
      // read pipelined into a write's data phase must see the new masked word
      htrans <= IMC_HTRANS_NONSEQ;
      haddr <= IMC_ADDR_MODE;
      hwrite <= 1'b1;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hwrite <= 1'b0;
      hwdata <= 32'hc1c2c3cc;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      do @(posedge clock); while (hreadyout !== 1'b1);
      chk(hrdata, 32'h41424344);
      chk_all(32'h41424344);
      // reset in mid-run clears a loaded register
      bus(1'b1, IMC_ADDR_MODE, 32'h5c5b5a59);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk_all(IMC_RESET);
      print_verdict();
   end
endmodule : imc_mode_ctrl_tb_top
